// ### dcar_ahb_peri.sv
// behavioural bus-side peripheral answering byte transfers of the channel
`timescale 1ns/1ps
module dcar_ahb_peri
   import dcar_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        ahbStart,
   input  wire logic [23:0] ahbAddr,
   input  wire logic        ahbWrite,
   input  wire logic [3:0]  latency,
   input  wire logic        errOn,
   input  wire logic        reqOn,
   output logic             ahbDone,
   output logic             ahbErr,
   output logic             dmaReq,
   output int               nStarts,
   output logic      [23:0] seenAddr,
   output logic             seenWrite
);
   // request level follows the reqOn input
   assign dmaReq = reqOn;
   initial begin
      ahbDone = 1'b0;
      ahbErr = 1'b1;
      nStarts = 0;
      seenAddr = 24'h000000;
      seenWrite = 1'b0;
      forever begin
         @(posedge clock);
         if (ahbStart === 1'b1) begin
            nStarts++;
            seenAddr = ahbAddr;
            seenWrite = ahbWrite;
            repeat (latency) @(posedge clock);
            @(negedge clock);
            ahbDone = 1'b1;
            ahbErr = errOn;
            @(negedge clock);
            ahbDone = 1'b0;
            // error line meaningless outside done
            ahbErr = ~errOn;
         end
      end
   end
endmodule : dcar_ahb_peri

// ### dcar_cfg.svh
// register offsets, field positions and reset values of the dma channel
`ifndef DCAR_CFG_SVH
`define DCAR_CFG_SVH
`define DCAR_OFS_CTRL   5'h00
`define DCAR_OFS_END    5'h04
`define DCAR_OFS_START  5'h08
`define DCAR_OFS_PERI   5'h0c
`define DCAR_OFS_ACT    5'h10
`define DCAR_BIT_RUN    0
`define DCAR_BIT_REQ    1
`define DCAR_BIT_DONE   2
`define DCAR_BIT_STAT   3
`define DCAR_BIT_BUSY   5
`define DCAR_BIT_DIR    8
`define DCAR_BIT_DEV    9
`define DCAR_BIT_ACT    0
`define DCAR_RST_OFS    16'h0000
`define DCAR_RST_PERI   24'h000000
`define DCAR_RST_ACT    1'h0
`endif

// ### dcar_channel.sv
// one dma channel: address registers, run control and byte sequencing
//
// Contract
// - stop when counter equals end offset
// - end offset is sixteen bits wide
// - equal offsets at run: no bytes, done
// - start offset is shared memory byte offset
// - counter loads start, increments per byte
// - start reads next byte offset while running
// - start reads last offset plus one after
// - peripheral address 24 bits, top reserved
// - activate bit zero gates channel clock
// - registers frozen while run is set, except the run bit
// - end match reports status 01
// - direction 0 reads peripheral, 1 writes
`timescale 1ns/1ps
`include "dcar_cfg.svh"
module dcar_channel
   import dcar_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        resetn,
   input  wire logic [4:0]  spbAddr,
   input  wire logic        spbWrEn,
   input  wire logic        spbRdEn,
   input  wire logic [3:0]  spbByteEn,
   input  wire logic [31:0] spbWrData,
   output logic      [31:0] spbRdData,
   input  wire logic        dmaReq,
   input  wire logic        dmaTerm,
   output logic      [23:0] ahbAddr,
   output logic             ahbWrite,
   output logic             ahbStart,
   input  wire logic        ahbDone,
   input  wire logic        ahbErr,
   output logic      [15:0] memAddr,
   output logic             memWriteEn,
   output logic             memStrobe,
   output logic             chanClkEn,
   output logic             chanDone,
   output logic      [2:0]  devSelect
);
   logic       [1:0] rstSync_ff;
   logic             rstN;
   dcar_chan_t       cur_ff;
   dcar_chan_t       nxt_cur;
   logic      [15:0] count;
   logic             atEnd;
   logic             cntLoad;
   logic             cntStep;
   logic             wrHit;

   function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
      hit = (a == ofs);
   endfunction : hit

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rstSync_ff <= 2'b00;
      end else begin
         rstSync_ff <= {rstSync_ff[0], 1'b1};
      end
   end
   assign rstN = rstSync_ff[1];

   assign wrHit = spbWrEn && !cur_ff.run;
   assign cntLoad = wrHit && hit(spbAddr, `DCAR_OFS_START) && (spbByteEn[1:0] == 2'b11);
   assign cntStep = cur_ff.active && (cur_ff.state == ST_XFER) && ahbDone && !ahbErr;

   // counter is the shared memory offset
   dcar_counter u_counter (
      .clock     (clock),
      .rstN      (rstN),
      .load      (cntLoad),
      .loadValue (spbWrData[15:0]),
      .step      (cntStep),
      .endValue  (cur_ff.endOfs),
      .count     (count),
      .atEnd     (atEnd)
   );

   always_comb begin
      nxt_cur           = cur_ff;
      nxt_cur.ahbStart  = 1'b0;
      nxt_cur.memStrobe = 1'b0;
      // control register: only run may change while running
      if (spbWrEn && hit(spbAddr, `DCAR_OFS_CTRL) && spbByteEn[0]) begin
         nxt_cur.run = spbWrData[`DCAR_BIT_RUN];
      end
      if (wrHit && hit(spbAddr, `DCAR_OFS_CTRL) && spbByteEn[1]) begin
         nxt_cur.dir = spbWrData[`DCAR_BIT_DIR];
         nxt_cur.dev = spbWrData[`DCAR_BIT_DEV +: 3];
      end
      if (wrHit && hit(spbAddr, `DCAR_OFS_END)) begin
         if (spbByteEn[0]) nxt_cur.endOfs[7:0] = spbWrData[7:0];
         if (spbByteEn[1]) nxt_cur.endOfs[15:8] = spbWrData[15:8];
      end
      if (wrHit && hit(spbAddr, `DCAR_OFS_PERI)) begin
         if (spbByteEn[0]) nxt_cur.periAddr[7:0] = spbWrData[7:0];
         if (spbByteEn[1]) nxt_cur.periAddr[15:8] = spbWrData[15:8];
         if (spbByteEn[2]) nxt_cur.periAddr[23:16] = spbWrData[23:16];
      end
      if (wrHit && hit(spbAddr, `DCAR_OFS_ACT) && spbByteEn[0]) begin
         nxt_cur.active = spbWrData[`DCAR_BIT_ACT];
      end
      nxt_cur.reqSeen = cur_ff.run && dmaReq;
      if (!cur_ff.run) begin
         nxt_cur.done   = 1'b0;
         nxt_cur.status = CS_RUNOFF;
      end
      if (cur_ff.active) begin
         case (cur_ff.state)
            ST_IDLE: begin
               if (cur_ff.run && !cur_ff.done) begin
                  if (atEnd) begin
                     nxt_cur.done   = 1'b1;
                     nxt_cur.status = CS_MATCH;
                  end else begin
                     nxt_cur.state = ST_WAIT;
                  end
               end
            end
            ST_WAIT: begin
               if (!cur_ff.run) begin
                  nxt_cur.state = ST_IDLE;
               end else if (atEnd) begin
                  nxt_cur.state  = ST_IDLE;
                  nxt_cur.done   = 1'b1;
                  nxt_cur.status = CS_MATCH;
               end else if (dmaTerm) begin
                  nxt_cur.state  = ST_IDLE;
                  nxt_cur.done   = 1'b1;
                  nxt_cur.status = CS_TERM;
               end else if (dmaReq) begin
                  nxt_cur.state    = ST_XFER;
                  nxt_cur.ahbStart = 1'b1;
               end
            end
            ST_XFER: begin
               if (ahbDone) begin
                  nxt_cur.memStrobe = !ahbErr;
                  nxt_cur.memAddr   = count;
                  if (!cur_ff.run) begin
                     nxt_cur.state = ST_IDLE;
                  end else if (!ahbErr && (count + 16'h0001 == cur_ff.endOfs)) begin
                     nxt_cur.state  = ST_IDLE;
                     nxt_cur.done   = 1'b1;
                     nxt_cur.status = CS_MATCH;
                  end else if (dmaTerm) begin
                     nxt_cur.state  = ST_IDLE;
                     nxt_cur.done   = 1'b1;
                     nxt_cur.status = CS_TERM;
                  end else if (ahbErr) begin
                     nxt_cur.state  = ST_IDLE;
                     nxt_cur.done   = 1'b1;
                     nxt_cur.status = CS_BUSERR;
                  end else begin
                     nxt_cur.state = ST_WAIT;
                  end
               end
            end
            default: begin
               nxt_cur.state = ST_IDLE;
            end
         endcase
      end
      // register read, reserved bits zero
      nxt_cur.rdData = 32'h00000000;
      if (spbRdEn) begin
         if (hit(spbAddr, `DCAR_OFS_CTRL)) begin
            nxt_cur.rdData[`DCAR_BIT_RUN]      = cur_ff.run;
            nxt_cur.rdData[`DCAR_BIT_REQ]      = cur_ff.reqSeen;
            nxt_cur.rdData[`DCAR_BIT_DONE]     = cur_ff.done;
            nxt_cur.rdData[`DCAR_BIT_STAT +: 2] = cur_ff.status;
            nxt_cur.rdData[`DCAR_BIT_BUSY]     = (cur_ff.state != ST_IDLE);
            nxt_cur.rdData[`DCAR_BIT_DIR]      = cur_ff.dir;
            nxt_cur.rdData[`DCAR_BIT_DEV +: 3] = cur_ff.dev;
         end else if (hit(spbAddr, `DCAR_OFS_END)) begin
            nxt_cur.rdData[15:0] = cur_ff.endOfs;
         end else if (hit(spbAddr, `DCAR_OFS_START)) begin
            nxt_cur.rdData[15:0] = count;
         end else if (hit(spbAddr, `DCAR_OFS_PERI)) begin
            nxt_cur.rdData[23:0] = cur_ff.periAddr;
         end else if (hit(spbAddr, `DCAR_OFS_ACT)) begin
            nxt_cur.rdData[`DCAR_BIT_ACT] = cur_ff.active;
         end
      end
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         cur_ff          <= '0;
         cur_ff.endOfs   <= `DCAR_RST_OFS;
         cur_ff.periAddr <= `DCAR_RST_PERI;
         cur_ff.active   <= `DCAR_RST_ACT;
      end else begin
         cur_ff <= nxt_cur;
      end
   end

   assign spbRdData  = cur_ff.rdData;
   assign ahbAddr    = cur_ff.periAddr;
   assign ahbWrite   = cur_ff.dir;
   assign memWriteEn = !cur_ff.dir;
   assign ahbStart   = cur_ff.ahbStart;
   assign memStrobe  = cur_ff.memStrobe;
   assign memAddr    = cur_ff.memAddr;
   assign chanClkEn  = cur_ff.active;
   assign chanDone   = cur_ff.done;
   assign devSelect  = cur_ff.dev;

   property p_end_match;
      @(posedge clock) disable iff (!rstN)
      (cur_ff.active && cur_ff.state == ST_XFER && ahbDone && !ahbErr && cur_ff.run
       && (count + 16'h0001 == cur_ff.endOfs))
      |=> (cur_ff.done && cur_ff.status == CS_MATCH && cur_ff.state == ST_IDLE);
   endproperty
   a_end_match: assert property (p_end_match) else $error("end match not reported");

   property p_empty;
      @(posedge clock) disable iff (!rstN)
      (cur_ff.active && cur_ff.state == ST_IDLE && cur_ff.run && !cur_ff.done && atEnd)
      |=> (cur_ff.done && cur_ff.status == CS_MATCH) ##1 !cur_ff.ahbStart;
   endproperty
   a_empty: assert property (p_empty) else $error("empty transfer moved data");

   property p_step;
      @(posedge clock) disable iff (!rstN)
      (cntStep && !cntLoad) |=> (count == $past(count) + 16'h0001);
   endproperty
   a_step: assert property (p_step) else $error("counter did not step by one");

   property p_done_count;
      @(posedge clock) disable iff (!rstN)
      (cur_ff.done && cur_ff.status == CS_MATCH) |-> atEnd;
   endproperty
   a_done_count: assert property (p_done_count) else $error("count not at end when done");

   property p_peri_read;
      @(posedge clock) disable iff (!rstN)
      (spbRdEn && spbAddr == `DCAR_OFS_PERI)
      |=> (spbRdData[31:24] == 8'h00 && spbRdData[23:0] == $past(cur_ff.periAddr));
   endproperty
   a_peri_read: assert property (p_peri_read) else $error("peripheral address read wrong");

   property p_inert;
      @(posedge clock) disable iff (!rstN)
      !cur_ff.active |=> (cur_ff.state == $past(cur_ff.state) && !ahbStart);
   endproperty
   a_inert: assert property (p_inert) else $error("gated channel moved");

   property p_frozen;
      @(posedge clock) disable iff (!rstN)
      (cur_ff.run && spbWrEn && (spbAddr == `DCAR_OFS_END || spbAddr == `DCAR_OFS_PERI))
      |=> (cur_ff.endOfs == $past(cur_ff.endOfs) && cur_ff.periAddr == $past(cur_ff.periAddr));
   endproperty
   a_frozen: assert property (p_frozen) else $error("register changed while running");

   property p_dir;
      @(posedge clock) disable iff (!rstN)
      (wrHit && spbAddr == `DCAR_OFS_CTRL && spbByteEn[1])
      |=> (ahbWrite == $past(spbWrData[`DCAR_BIT_DIR]) && memWriteEn == !ahbWrite);
   endproperty
   a_dir: assert property (p_dir) else $error("direction mismatch");

   property p_run_off;
      @(posedge clock) disable iff (!rstN)
      !cur_ff.run |=> (cur_ff.status == CS_RUNOFF && !cur_ff.done);
   endproperty
   a_run_off: assert property (p_run_off) else $error("status not cleared with run");

   c_byte: cover property (@(posedge clock) disable iff (!rstN) memStrobe);
   c_match: cover property (@(posedge clock) disable iff (!rstN)
      cur_ff.done && cur_ff.status == CS_MATCH);
   c_err: cover property (@(posedge clock) disable iff (!rstN)
      cur_ff.done && cur_ff.status == CS_BUSERR);
   c_term: cover property (@(posedge clock) disable iff (!rstN)
      cur_ff.done && cur_ff.status == CS_TERM);
endmodule : dcar_channel

// ### dcar_counter.sv
// sixteen bit running memory offset counter
`timescale 1ns/1ps
`include "dcar_cfg.svh"
module dcar_counter
   import dcar_pkg::*;
(
   input  wire logic        clock,
   input  wire logic        rstN,
   input  wire logic        load,
   input  wire logic [15:0] loadValue,
   input  wire logic        step,
   input  wire logic [15:0] endValue,
   output logic      [15:0] count,
   output logic             atEnd
);
   dcar_cnt_t cnt_ff;
   dcar_cnt_t nxt_cnt;

   always_comb begin
      nxt_cnt = cnt_ff;
      if (load) begin
         nxt_cnt.count = loadValue;
      end else if (step) begin
         nxt_cnt.count = cnt_ff.count + 16'h0001;
      end
   end

   always_ff @(posedge clock or negedge rstN) begin
      if (!rstN) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   assign count = cnt_ff.count;
   assign atEnd = (cnt_ff.count == endValue);
endmodule : dcar_counter

// ### dcar_pkg.sv
// types shared by the dma channel modules
package dcar_pkg;
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_WAIT = 2'b01,
      ST_XFER = 2'b10
   } dcar_state_t;

   typedef enum logic [1:0] {
      CS_RUNOFF = 2'b00,
      CS_MATCH  = 2'b01,
      CS_TERM   = 2'b10,
      CS_BUSERR = 2'b11
   } dcar_status_t;

   typedef struct packed {
      dcar_state_t  state;
      logic         run;
      logic         dir;
      logic [2:0]   dev;
      logic         done;
      dcar_status_t status;
      logic         reqSeen;
      logic [15:0]  endOfs;
      logic [23:0]  periAddr;
      logic         active;
      logic [31:0]  rdData;
      logic         ahbStart;
      logic         memStrobe;
      logic [15:0]  memAddr;
   } dcar_chan_t;

   typedef struct packed {
      logic [15:0] count;
   } dcar_cnt_t;
endpackage : dcar_pkg

// ### dma_channel_address_regs_bench.sv
// self-checking bench of one dma channel against the peripheral model
`timescale 1ns/1ps
`include "dcar_cfg.svh"
module dma_channel_address_regs_bench
   import dcar_pkg::*;
;
   logic        clock, resetn, spbWrEn, spbRdEn, dmaTerm, errOn, reqOn;
   logic        ahbWrite, ahbStart, ahbDone, ahbErr, memWriteEn, memStrobe;
   logic        chanClkEn, chanDone, dmaReq, peerWrite;
   logic [4:0]  spbAddr;
   logic [3:0]  spbByteEn, latency;
   logic [31:0] spbWrData, spbRdData, q;
   logic [23:0] ahbAddr, peerAddr;
   logic [15:0] memAddr;
   logic [2:0]  devSelect;
   logic [15:0] seenQ[$];
   int          nErrors, nChecks, nStarts, k;
   logic [15:0] endV[4] = '{16'h0008, 16'h0008, 16'h0008, 16'h0000};
   logic        termV[4] = '{1'b0, 1'b1, 1'b1, 1'b1};
   logic        errV[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
   logic [1:0]  expS[4] = '{CS_BUSERR, CS_TERM, CS_TERM, CS_MATCH};

   dcar_channel dut (.clock(clock), .resetn(resetn), .spbAddr(spbAddr), .spbWrEn(spbWrEn),
      .spbRdEn(spbRdEn), .spbByteEn(spbByteEn), .spbWrData(spbWrData), .spbRdData(spbRdData),
      .dmaReq(dmaReq), .dmaTerm(dmaTerm), .ahbAddr(ahbAddr), .ahbWrite(ahbWrite),
      .ahbStart(ahbStart), .ahbDone(ahbDone), .ahbErr(ahbErr), .memAddr(memAddr),
      .memWriteEn(memWriteEn), .memStrobe(memStrobe), .chanClkEn(chanClkEn),
      .chanDone(chanDone), .devSelect(devSelect));
   dcar_ahb_peri peer (.clock(clock), .ahbStart(ahbStart), .ahbAddr(ahbAddr),
      .ahbWrite(ahbWrite), .latency(latency), .errOn(errOn), .reqOn(reqOn),
      .ahbDone(ahbDone), .ahbErr(ahbErr), .dmaReq(dmaReq), .nStarts(nStarts),
      .seenAddr(peerAddr), .seenWrite(peerWrite));

   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(negedge clock) begin
      if (memStrobe === 1'b1) seenQ.push_back(memAddr);
   end

   task giveVerdict();
      $display("checks %0d mismatches %0d", nChecks, nErrors);
      if (nErrors == 0 && nChecks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : giveVerdict
   task check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      nChecks++;
      if (seen !== exp) begin
         nErrors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge clock); spbAddr = a; spbWrData = d; spbByteEn = be; spbWrEn = 1'b1;
      @(negedge clock); spbWrEn = 1'b0;
   endtask : wr
   task rd(input logic [4:0] a);
      @(negedge clock); spbAddr = a; spbRdEn = 1'b1;
      @(negedge clock); spbRdEn = 1'b0; q = spbRdData;
   endtask : rd
   task runCh(input logic [2:0] dev, input logic dir);
      wr(`DCAR_OFS_CTRL, {20'h0, dev, dir, 7'h00, 1'b1}, 4'hf);
   endtask : runCh
   task waitDone();
      k = 0;
      while (chanDone !== 1'b1 && k < 300) begin @(negedge clock); k++; end
      check("done", {31'h0, chanDone}, 32'h1);
   endtask : waitDone

   initial begin
      #(100 * 5000);
      nErrors++;
      giveVerdict();
   end

   initial begin
      {resetn, spbWrEn, spbRdEn, dmaTerm, errOn, reqOn} = '0;
      spbAddr = '0; spbByteEn = '0; spbWrData = '0; latency = '0; nErrors = 0; nChecks = 0;
      repeat (5) @(negedge clock);
      resetn = 1'b1;
      repeat (3) @(posedge clock);
      rd(`DCAR_OFS_END); check("end rst", q, 32'h0);
      rd(`DCAR_OFS_START); check("start rst", q, 32'h0);
      rd(`DCAR_OFS_PERI); check("peri rst", q, 32'h0);
      rd(`DCAR_OFS_ACT); check("act rst", q, {31'h0, `DCAR_RST_ACT});
      rd(5'h14); check("unmapped", q, 32'h0);
      wr(`DCAR_OFS_END, 32'hffffffff, 4'hf);
      rd(`DCAR_OFS_END); check("end rw", {16'h0, q[15:0]}, 32'hffff);
      wr(`DCAR_OFS_PERI, 32'hffffffff, 4'hf);
      rd(`DCAR_OFS_PERI); check("peri rsv", q, 32'h00ffffff);
      wr(`DCAR_OFS_ACT, 32'hffffffff, 4'hf);
      rd(`DCAR_OFS_ACT); check("act rsv", q, 32'h1);
      check("clk en", {31'h0, chanClkEn}, 32'h1);
      wr(`DCAR_OFS_START, 32'h0000abcd, 4'h1);
      rd(`DCAR_OFS_START); check("start byte", {16'h0, q[15:0]}, 32'h0);
      $display("test registers done");
      wr(`DCAR_OFS_START, 32'h5, 4'h3);
      wr(`DCAR_OFS_END, 32'h5, 4'h3);
      runCh(3'h4, 1'b0);
      repeat (3) @(negedge clock);
      check("done eq", {31'h0, chanDone}, 32'h1);
      rd(`DCAR_OFS_CTRL); check("stat eq", {30'h0, q[4:3]}, {30'h0, CS_MATCH});
      check("starts eq", nStarts, 0);
      wr(`DCAR_OFS_CTRL, 32'h0, 4'hf);
      rd(`DCAR_OFS_CTRL); check("ctrl off", {27'h0, q[4:0]}, 32'h0);
      $display("test empty transfer done");
      wr(`DCAR_OFS_ACT, 32'h0, 4'hf);
      wr(`DCAR_OFS_START, 32'h10, 4'h3);
      wr(`DCAR_OFS_END, 32'h13, 4'h3);
      wr(`DCAR_OFS_PERI, 32'h123456, 4'hf);
      latency = 4'h8; reqOn = 1'b1;
      runCh(3'h1, 1'b1);
      repeat (10) @(negedge clock);
      check("gated", nStarts, 0);
      wr(`DCAR_OFS_CTRL, 32'h0, 4'hf);
      wr(`DCAR_OFS_ACT, 32'h1, 4'hf);
      runCh(3'h1, 1'b1);
      k = 0;
      while (seenQ.size() == 0 && k < 60) begin @(negedge clock); k++; end
      rd(`DCAR_OFS_START); check("start mid", {16'h0, q[15:0]}, 32'h11);
      wr(`DCAR_OFS_END, 32'h20, 4'h3);
      wr(`DCAR_OFS_ACT, 32'h0, 4'hf);
      check("act frozen", {31'h0, chanClkEn}, 32'h1);
      wr(`DCAR_OFS_CTRL, 32'h00000f01, 4'hf);
      check("dev frozen", {29'h0, devSelect}, 32'h1);
      check("ahb addr", {8'h0, peerAddr}, 32'h123456);
      check("ahb write", {31'h0, peerWrite}, 32'h1);
      check("mem we", {31'h0, memWriteEn}, 32'h0);
      waitDone();
      rd(`DCAR_OFS_START); check("start end", {16'h0, q[15:0]}, 32'h13);
      rd(`DCAR_OFS_END); check("end frozen", {16'h0, q[15:0]}, 32'h13);
      check("bytes", seenQ.size(), 3);
      for (int i = 0; i < 3; i++) begin
         check("mem addr", {16'h0, seenQ[i]}, 32'h10 + i);
      end
      rd(`DCAR_OFS_CTRL); check("stat match", {30'h0, q[4:3]}, {30'h0, CS_MATCH});
      wr(`DCAR_OFS_CTRL, 32'h0, 4'hf);
      $display("test transfer done");
      latency = 4'h0;
      for (int i = 0; i < 4; i++) begin
         wr(`DCAR_OFS_START, 32'h0, 4'h3);
         wr(`DCAR_OFS_END, {16'h0, endV[i]}, 4'h3);
         dmaTerm = termV[i]; errOn = errV[i];
         runCh(i[2:0], 1'b0);
         waitDone();
         rd(`DCAR_OFS_CTRL); check("stat end", {30'h0, q[4:3]}, {30'h0, expS[i]});
         check("mem we rd", {31'h0, memWriteEn}, 32'h1);
         wr(`DCAR_OFS_CTRL, 32'h0, 4'hf);
         dmaTerm = 1'b0; errOn = 1'b0;
      end
      $display("test endings done");
      giveVerdict();
   end
endmodule : dma_channel_address_regs_bench
